/* File: design/fsp_status_protect.sv */
/*
 Status registers and write protection of a serial NOR flash, reached over
 the serial pins, which the system clock oversamples.
 Assumes the array engine reports op_done after op_start and the serial
 clock is slow enough for two-flop sampling.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fsp_defs.svh"

module fsp_status_protect
   import fsp_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        arst_n,
   input  wire logic        sclk,
   input  wire logic        cs_n,
   input  wire logic        si,
   input  wire logic        wp_n,
   output logic             so,
   output logic             so_oe_n,
   input  wire logic [15:0] nv_image_in,
   output logic      [15:0] nv_image_out,
   input  wire logic        op_done,
   output logic             op_start,
   output fsp_op_t          op_kind,
   output logic      [23:0] op_addr,
   output logic             op_suspend,
   output logic             op_resume,
   output logic             op_abort,
   output logic             busy_flag,
   output logic             write_latch,
   output logic             suspended_flag,
   output logic             quad_enable,
   output logic             dummy_cycle_select,
   output logic      [1:0]  security_lock
);

   // ----------------------------------------------------------------
   // Reset and pin sampling
   // ----------------------------------------------------------------
   logic       rst_n;
   logic [3:0] pins_s;
   logic       sclk_s, cs_s, si_s, wp_s;
   logic       sclk_d_ff, cs_d_ff;
   logic       sclk_rise, sclk_fall, cs_rise;

   fsp_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_rst_sync (
      .clock (clock),
      .rst_n (arst_n),
      .d     (1'b1),
      .q     (rst_n)
   );

   fsp_sync #(.WIDTH(4), .RST_VAL(4'h5)) u_pin_sync (
      .clock (clock),
      .rst_n (rst_n),
      .d     ({sclk, cs_n, si, wp_n}),
      .q     (pins_s)
   );

   assign {sclk_s, cs_s, si_s, wp_s} = pins_s;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sclk_d_ff <= 1'b0;
         cs_d_ff   <= 1'b1;
      end else begin
         sclk_d_ff <= sclk_s;
         cs_d_ff   <= cs_s;
      end
   end

   assign sclk_rise = sclk_s & ~sclk_d_ff;
   assign sclk_fall = ~sclk_s & sclk_d_ff;
   assign cs_rise   = cs_s & ~cs_d_ff;

   // ----------------------------------------------------------------
   // Byte framing
   // ----------------------------------------------------------------
   logic [7:0]  shift_ff, nxt_shift, cmd_ff, data1_ff, data2_ff;
   logic [2:0]  bit_cnt_ff, byte_cnt_ff;
   logic [23:0] addr_ff;
   logic        byte_done;

   assign nxt_shift = {shift_ff[6:0], si_s};
   assign byte_done = ~cs_s & sclk_rise & (bit_cnt_ff == 3'h7);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         shift_ff    <= 8'h00;
         bit_cnt_ff  <= 3'h0;
         byte_cnt_ff <= 3'h0;
      end else if (cs_s) begin
         bit_cnt_ff  <= 3'h0;
         byte_cnt_ff <= 3'h0;
      end else if (sclk_rise) begin
         shift_ff   <= nxt_shift;
         bit_cnt_ff <= bit_cnt_ff + 3'h1;
         if (bit_cnt_ff == 3'h7 && byte_cnt_ff != 3'h7) begin
            byte_cnt_ff <= byte_cnt_ff + 3'h1;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cmd_ff   <= 8'h00;
         data1_ff <= 8'h00;
         data2_ff <= 8'h00;
         addr_ff  <= 24'h000000;
      end else if (byte_done) begin
         unique case (byte_cnt_ff)
            3'h0: cmd_ff <= nxt_shift;
            3'h1: begin
               addr_ff[23:16] <= nxt_shift;
               data1_ff       <= nxt_shift;
            end
            3'h2: begin
               addr_ff[15:8] <= nxt_shift;
               data2_ff      <= nxt_shift;
            end
            3'h3: addr_ff[7:0] <= nxt_shift;
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Status bits and command decode
   // ----------------------------------------------------------------
   fsp_state_t state_ff;
   logic [15:0] nv_ff, nxt_nv;
   logic        latch_ff, load_pending_ff, rst_armed_ff;
   logic [1:0]  guard;
   logic [4:0]  bp;
   logic        cmp, wp_eff, sr_locked, is_idle;
   logic        framed, one_byte, c_wren, c_wrdi, c_status_write_cmd, c_pp, c_erase;
   logic        c_chip, c_susp, c_resume, c_rsten, c_rst;
   logic        sr_write_ok, do_array, chip_ok, hit;

   assign guard   = {nv_ff[`FSP_BIT_GUARD1], nv_ff[`FSP_BIT_GUARD0]};
   assign bp      = nv_ff[`FSP_BIT_BP_HI:`FSP_BIT_BP_LO];
   assign cmp     = nv_ff[`FSP_BIT_CMP];
   assign is_idle = (state_ff == FSP_IDLE);

   assign wp_eff    = nv_ff[`FSP_BIT_QE] | wp_s;
   assign sr_locked = (guard == 2'h1 && !wp_eff) || guard[1];

   assign framed   = cs_rise && bit_cnt_ff == 3'h0 && byte_cnt_ff != 3'h0;
   assign one_byte = framed && byte_cnt_ff == 3'h1;
   assign c_wren   = one_byte && cmd_ff == `FSP_OP_WREN && is_idle;
   assign c_wrdi   = one_byte && cmd_ff == `FSP_OP_WRDI && is_idle;
   assign c_status_write_cmd   = framed && cmd_ff == `FSP_OP_STATUS_WRITE_CMD && is_idle &&
                     (byte_cnt_ff == 3'h2 || byte_cnt_ff == 3'h3);
   assign c_pp     = framed && cmd_ff == `FSP_OP_PAGE && is_idle && byte_cnt_ff >= 3'h5;
   assign c_erase  = framed && byte_cnt_ff == 3'h4 && is_idle &&
                     (cmd_ff == `FSP_OP_SECT || cmd_ff == `FSP_OP_BLK32 ||
                      cmd_ff == `FSP_OP_BLK64);
   assign c_chip   = one_byte && is_idle &&
                     (cmd_ff == `FSP_OP_CHIP1 || cmd_ff == `FSP_OP_CHIP2);
   assign c_susp   = one_byte && cmd_ff == `FSP_OP_SUSP && state_ff == FSP_ARRAY;
   assign c_resume = one_byte && cmd_ff == `FSP_OP_RESUME && state_ff == FSP_SUSP;
   assign c_rsten  = one_byte && cmd_ff == `FSP_OP_RSTEN;
   assign c_rst    = one_byte && cmd_ff == `FSP_OP_RST && rst_armed_ff &&
                     (is_idle || state_ff == FSP_SUSP);

   assign sr_write_ok = c_status_write_cmd && latch_ff && !sr_locked;
   assign chip_ok     = (bp[2:0] == 3'h0 && !cmp) ||
                        (bp[2:0] == 3'h7 && cmp);
   assign do_array    = latch_ff && (((c_pp || c_erase) && !hit) ||
                        (c_chip && chip_ok));

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rst_armed_ff <= 1'b0;
      end else if (framed) begin
         rst_armed_ff <= c_rsten;
      end
   end

   // ----------------------------------------------------------------
   // Protected region decode
   // ----------------------------------------------------------------
   logic [20:0] p_size, n_lo, n_hi;
   logic [19:0] p_lo, p_hi, span, req_lo, req_hi;
   logic        p_none, p_all, p_top, prot_en;

   always_comb begin
      p_none = 1'b0;
      p_all  = 1'b0;
      p_top  = ~bp[3];
      p_size = 21'h000000;
      if (bp[2:0] == 3'h0) begin
         p_none = 1'b1;
      end else if (bp[2:1] == 2'h3 || (!bp[4] && bp[2:0] == 3'h5)) begin
         p_all = 1'b1;
      end else if (bp[4]) begin
         p_size = bp[2] ? (`FSP_SECT_SZ << 3) : (`FSP_SECT_SZ << (bp[1:0] - 2'h1));
      end else begin
         p_size = `FSP_BLOCK_SZ << (bp[2:0] - 3'h1);
      end
      n_lo = p_top ? (`FSP_ARRAY_SZ - p_size) : 21'h000000;
      n_hi = p_top ? {1'b0, `FSP_ARRAY_TOP} : (p_size - 21'h000001);
      if (cmp) begin
         n_lo = p_top ? 21'h000000 : p_size;
         n_hi = p_top ? (`FSP_ARRAY_SZ - p_size - 21'h000001) : {1'b0, `FSP_ARRAY_TOP};
      end
      prot_en = cmp ? ~p_all : ~p_none;
      if (cmp ? p_none : p_all) begin
         n_lo = 21'h000000;
         n_hi = {1'b0, `FSP_ARRAY_TOP};
      end
      p_lo = n_lo[19:0];
      p_hi = n_hi[19:0];
   end

   always_comb begin
      unique case (cmd_ff)
         `FSP_OP_SECT:  span = `FSP_SPAN_SECT;
         `FSP_OP_BLK32: span = `FSP_SPAN_B32;
         `FSP_OP_BLK64: span = `FSP_SPAN_B64;
         default:       span = `FSP_SPAN_PAGE;
      endcase
      req_lo = addr_ff[19:0] & ~span;
      req_hi = req_lo | span;
   end

   assign hit = prot_en && req_lo <= p_hi && req_hi >= p_lo;

   // ----------------------------------------------------------------
   // Non-volatile image and write latch
   // ----------------------------------------------------------------
   always_comb begin
      nxt_nv = nv_ff;
      nxt_nv[`FSP_BIT_GUARD0:`FSP_BIT_BP_LO] = data1_ff[7:2];
      if (byte_cnt_ff == 3'h3) begin
         nxt_nv[`FSP_BIT_GUARD1] = data2_ff[0];
         nxt_nv[`FSP_BIT_QE]     = data2_ff[1];
         nxt_nv[`FSP_BIT_LB1:`FSP_BIT_LB0] = nv_ff[`FSP_BIT_LB1:`FSP_BIT_LB0] |
                                             data2_ff[3:2];
         nxt_nv[`FSP_BIT_DC]     = data2_ff[4];
         nxt_nv[`FSP_BIT_CMP]    = data2_ff[6];
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         nv_ff           <= `FSP_NV_RST;
         load_pending_ff <= 1'b1;
      end else if (load_pending_ff) begin
         load_pending_ff <= 1'b0;
         nv_ff           <= nv_image_in & `FSP_NV_MASK;
         if (nv_image_in[`FSP_BIT_GUARD1:`FSP_BIT_GUARD0] == 2'h2) begin
            nv_ff[`FSP_BIT_GUARD1:`FSP_BIT_GUARD0] <= 2'h0;
         end
      end else if (sr_write_ok) begin
         nv_ff <= nxt_nv;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         latch_ff <= 1'b0;
      end else if (c_wren) begin
         latch_ff <= 1'b1;
      end else if (c_wrdi || c_status_write_cmd || c_pp || c_erase || c_chip || c_rst) begin
         latch_ff <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Busy and suspend sequencing
   // ----------------------------------------------------------------
   logic [7:0] srw_cnt_ff;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= FSP_IDLE;
      end else begin
         unique case (state_ff)
            FSP_IDLE: begin
               if (sr_write_ok) begin
                  state_ff <= FSP_SRW;
               end else if (do_array) begin
                  state_ff <= FSP_ARRAY;
               end
            end
            FSP_SRW: begin
               if (srw_cnt_ff == 8'h01) begin
                  state_ff <= FSP_IDLE;
               end
            end
            FSP_ARRAY: begin
               if (op_done) begin
                  state_ff <= FSP_IDLE;
               end else if (c_susp) begin
                  state_ff <= FSP_SUSP;
               end
            end
            FSP_SUSP: begin
               if (c_resume) begin
                  state_ff <= FSP_ARRAY;
               end else if (c_rst) begin
                  state_ff <= FSP_IDLE;
               end
            end
            default: state_ff <= FSP_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         srw_cnt_ff <= 8'h00;
      end else if (sr_write_ok) begin
         srw_cnt_ff <= 8'(`FSP_SRW_CYCLES);
      end else if (srw_cnt_ff != 8'h00) begin
         srw_cnt_ff <= srw_cnt_ff - 8'h01;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         op_start   <= 1'b0;
         op_kind    <= FSP_K_PAGE;
         op_addr    <= 24'h000000;
         op_suspend <= 1'b0;
         op_resume  <= 1'b0;
         op_abort   <= 1'b0;
      end else begin
         op_start   <= do_array;
         op_suspend <= c_susp;
         op_resume  <= c_resume;
         op_abort   <= c_rst && state_ff == FSP_SUSP;
         if (do_array) begin
            op_addr <= addr_ff;
            unique case (cmd_ff)
               `FSP_OP_SECT:  op_kind <= FSP_K_SECT;
               `FSP_OP_BLK32: op_kind <= FSP_K_BLK32;
               `FSP_OP_BLK64: op_kind <= FSP_K_BLK64;
               `FSP_OP_PAGE:  op_kind <= FSP_K_PAGE;
               default:       op_kind <= FSP_K_CHIP;
            endcase
         end
      end
   end

   assign busy_flag          = (state_ff == FSP_SRW) || (state_ff == FSP_ARRAY);
   assign suspended_flag     = (state_ff == FSP_SUSP);
   assign write_latch        = latch_ff;
   assign nv_image_out       = nv_ff;
   assign quad_enable        = nv_ff[`FSP_BIT_QE];
   assign dummy_cycle_select = nv_ff[`FSP_BIT_DC];
   assign security_lock      = nv_ff[`FSP_BIT_LB1:`FSP_BIT_LB0];

   // ----------------------------------------------------------------
   // Status read-out
   // ----------------------------------------------------------------
   logic [7:0] sr_low, sr_high, rd_byte;
   logic       rd_active_ff, rd_sel_ff, so_ff, so_oe_n_ff;
   logic [2:0] rd_idx_ff;

   assign sr_low  = {nv_ff[`FSP_BIT_GUARD0:`FSP_BIT_BP_LO], latch_ff, busy_flag};
   assign sr_high = {suspended_flag, cmp, 1'b0, nv_ff[`FSP_BIT_DC:`FSP_BIT_GUARD1]};
   assign rd_byte = rd_sel_ff ? sr_high : sr_low;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rd_active_ff <= 1'b0;
         rd_sel_ff    <= 1'b0;
         rd_idx_ff    <= 3'h0;
         so_ff        <= 1'b0;
         so_oe_n_ff   <= 1'b1;
      end else if (cs_s) begin
         rd_active_ff <= 1'b0;
         rd_idx_ff    <= 3'h0;
         so_oe_n_ff   <= 1'b1;
      end else if (byte_done && byte_cnt_ff == 3'h0) begin
         rd_active_ff <= nxt_shift == `FSP_OP_RDSR1 || nxt_shift == `FSP_OP_RDSR2;
         rd_sel_ff    <= nxt_shift == `FSP_OP_RDSR2;
      end else if (sclk_fall && rd_active_ff) begin
         so_ff      <= rd_byte[3'h7 - rd_idx_ff];
         rd_idx_ff  <= rd_idx_ff + 3'h1;
         so_oe_n_ff <= 1'b0;
      end
   end

   assign so      = so_ff;
   assign so_oe_n = so_oe_n_ff;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_busy_on_srw: assert property (sr_write_ok |=> busy_flag [*8])
      else $error("busy not held after status write");
   a_latch_gate: assert property ((c_pp || c_erase || c_chip) && !latch_ff |=> !op_start && !busy_flag)
      else $error("array command ran without write latch");
   a_prot_reject: assert property ((c_pp || c_erase) && hit |=> !op_start ##1 !busy_flag)
      else $error("protected command started");
   a_chip_gate: assert property (c_chip && latch_ff && !chip_ok |=> !op_start)
      else $error("chip erase ran with protect code set");
   a_hw_lock: assert property (c_status_write_cmd && guard == 2'h1 && !wp_eff |=> $stable(nv_ff))
      else $error("status written while hardware locked");
   a_power_lock: assert property (c_status_write_cmd && guard == 2'h2 |=> $stable(nv_ff) && !busy_flag)
      else $error("status written in power lock");
   a_otp_lock: assert property (c_status_write_cmd && guard == 2'h3 |=> $stable(nv_ff))
      else $error("status written in permanent lock");
   a_sw_write: assert property (c_status_write_cmd && latch_ff && guard == 2'h0 |=>
                                nv_ff[`FSP_BIT_GUARD0:`FSP_BIT_BP_LO] == $past(data1_ff[7:2]))
      else $error("status write lost with guard clear");
   a_lock_keep: assert property (!load_pending_ff && nv_ff[`FSP_BIT_LB0] |=> nv_ff[`FSP_BIT_LB0])
      else $error("security lock cleared");
   a_guard_boot: assert property (load_pending_ff && nv_image_in[8:7] == 2'h2 |=> guard == 2'h0)
      else $error("power lock survived power cycle");
   a_latch_clear: assert property (c_wrdi || c_status_write_cmd || c_pp || c_erase |=> !write_latch)
      else $error("write latch not cleared");
   a_suspend: assert property (c_susp |=> suspended_flag && !busy_flag ##1 op_suspend == 1'b0)
      else $error("suspend flag not set");
   a_cmp_none: assert property (cmp && !bp[4] && bp[2:1] == 2'h3 |-> !prot_en)
      else $error("complement code should protect nothing");
   a_cmp_upper: assert property (cmp && bp == 5'h11 |-> prot_en && p_lo == 20'h00000 && p_hi == 20'hfefff)
      else $error("complement upper region wrong");
   a_quad_pin: assert property (nv_ff[`FSP_BIT_QE] && guard == 2'h1 |-> !sr_locked)
      else $error("protect pin acted while quad enabled");

   c_status_write: cover property (sr_write_ok ##1 busy_flag);
   c_array_run: cover property (op_start ##[1:1000] !busy_flag);
   c_rejected: cover property ((c_pp || c_erase) && hit && latch_ff);
   c_suspend_resume: cover property (c_susp ##[1:1000] c_resume);

endmodule // fsp_status_protect

`default_nettype wire

/* File: pkg/fsp_defs.svh */
/*
 Constants of the flash status and protection block: opcodes, status bit
 positions, reset values, array geometry and timing counts.
 Assumes it is included by bare name after the package.
*/
`ifndef FSP_DEFS_SVH
`define FSP_DEFS_SVH

`define FSP_OP_WREN    8'h06
`define FSP_OP_WRDI    8'h04
`define FSP_OP_RDSR1   8'h05
`define FSP_OP_RDSR2   8'h35
`define FSP_OP_STATUS_WRITE_CMD    8'h01
`define FSP_OP_PAGE    8'h02
`define FSP_OP_SECT    8'h20
`define FSP_OP_BLK32   8'h52
`define FSP_OP_BLK64   8'hd8
`define FSP_OP_CHIP1   8'h60
`define FSP_OP_CHIP2   8'hc7
`define FSP_OP_SUSP    8'h75
`define FSP_OP_RESUME  8'h7a
`define FSP_OP_RSTEN   8'h66
`define FSP_OP_RST     8'h99

`define FSP_BIT_BUSY   0
`define FSP_BIT_LATCH  1
`define FSP_BIT_BP_LO  2
`define FSP_BIT_BP_HI  6
`define FSP_BIT_GUARD0 7
`define FSP_BIT_GUARD1 8
`define FSP_BIT_QE     9
`define FSP_BIT_LB0    10
`define FSP_BIT_LB1    11
`define FSP_BIT_DC     12
`define FSP_BIT_CMP    14

`define FSP_NV_MASK    16'h5ffc
`define FSP_NV_RST     16'h0000

`define FSP_SECT_SZ    21'h001000
`define FSP_BLOCK_SZ   21'h010000
`define FSP_ARRAY_SZ   21'h100000
`define FSP_ARRAY_TOP  20'hfffff
`define FSP_SPAN_PAGE  20'h000ff
`define FSP_SPAN_SECT  20'h00fff
`define FSP_SPAN_B32   20'h07fff
`define FSP_SPAN_B64   20'h0ffff

`define FSP_CLK_PERIOD_NS 5
`define FSP_T_SRW_NS      1000
`define FSP_SRW_CYCLES    ((`FSP_T_SRW_NS + `FSP_CLK_PERIOD_NS - 1) / `FSP_CLK_PERIOD_NS)

`endif

/* File: pkg/fsp_pkg.sv */
/*
 Types of the flash status and protection block.
 Assumes nothing of its surroundings.
*/
package fsp_pkg;

   typedef enum logic [3:0] {
      FSP_IDLE  = 4'h1,
      FSP_SRW   = 4'h2,
      FSP_ARRAY = 4'h4,
      FSP_SUSP  = 4'h8
   } fsp_state_t;

   typedef enum logic [2:0] {
      FSP_K_PAGE  = 3'h0,
      FSP_K_SECT  = 3'h1,
      FSP_K_BLK32 = 3'h2,
      FSP_K_BLK64 = 3'h3,
      FSP_K_CHIP  = 3'h4
   } fsp_op_t;

endpackage

/* File: design/fsp_sync.sv */
/*
 Two-flop synchroniser for a group of levels.
 Assumes the reset given is the one of the destination clock domain.
*/
`timescale 1ns/100ps
`default_nettype none

module fsp_sync #(
   parameter int unsigned       WIDTH   = 1,
   parameter logic [WIDTH-1:0]  RST_VAL = '0
) (
   input  wire logic             clock,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] q_ff;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= RST_VAL;
         q_ff    <= RST_VAL;
      end else begin
         meta_ff <= d;
         q_ff    <= meta_ff;
      end
   end

   assign q = q_ff;

endmodule // fsp_sync

`default_nettype wire

/* File: verification/fsp_spi_host.sv */
/*
 Host model on the serial pins: mode 0 frames, most significant bit first.
 Assumes the bench clock paces it; sclk rests low between frames.
*/
`timescale 1ns/100ps
`default_nettype none

module fsp_spi_host (
   input  wire logic clock,
   input  wire logic so,
   output logic      sclk,
   output logic      cs_n,
   output logic      si
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      si   = 1'b0;
   end

   // Sends nbits of tx and samples so at every rising sclk.
   task automatic frame(input logic [39:0] tx, input int nbits, output logic [15:0] rx);
      rx = 16'h0000;
      @(posedge clock) #1 cs_n = 1'b0;
      for (int i = nbits - 1; i >= 0; i--) begin
         si = tx[i];
         repeat (16) @(posedge clock);
         #1 sclk = 1'b1;
         rx = {rx[14:0], so};
         repeat (16) @(posedge clock);
         #1 sclk = 1'b0;
      end
      repeat (16) @(posedge clock);
      #1 cs_n = 1'b1;
      si = ~si;
      repeat (16) @(posedge clock);
   endtask
endmodule // fsp_spi_host

`default_nettype wire

/* File: verification/tb_fsp_status_protect.sv */
/*
 Bench of the status and protection block: host model on the pins, a
 stand-in array engine on op_start and op_done.
 Assumes the package and the host model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none

module tb_fsp_status_protect import fsp_pkg::*; ;
   logic        clock = 1'b0, arst_n = 1'b0, wp_n = 1'b1, op_done = 1'b0;
   logic [15:0] nv_in = 16'h0000, nv;
   logic        sclk, cs_n, si, so, start, busy, latch, susp, qe, dcs, abort, oe_n;
   logic [23:0] addr;
   logic [1:0]  lock;
   fsp_op_t     kind;
   int          num_errors = 0, checks_done = 0, cycles = 0, starts = 0, eng = 0, aborts = 0;

   fsp_spi_host fsp_spi_host_i (.clock(clock), .so(so), .sclk(sclk), .cs_n(cs_n), .si(si));
   fsp_status_protect fsp_status_protect_i (.clock(clock), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n),
      .si(si), .wp_n(wp_n), .so(so), .so_oe_n(oe_n), .nv_image_in(nv_in), .nv_image_out(nv), .op_done(op_done),
      .op_start(start), .op_kind(kind), .op_addr(addr), .op_suspend(), .op_resume(), .op_abort(abort),
      .busy_flag(busy), .write_latch(latch), .suspended_flag(susp), .quad_enable(qe),
      .dummy_cycle_select(dcs), .security_lock(lock));

   // ------------------------------------------------------------
   // Clock, array engine stand-in (halts while suspended), helpers
   // ------------------------------------------------------------
   always #2.5 clock = ~clock;
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (start) begin
         starts <= starts + 1;
         eng    <= 900;
      end else if (abort) begin
         aborts <= aborts + 1;
         eng    <= 0;
      end else if (eng > 0 && !susp) begin
         eng <= eng - 1;
      end
      op_done <= #1 (eng == 1 && !susp);
      if (cycles == 60000) begin
         num_errors++;
         conclude();
      end
   end

   task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic cmd(input logic [39:0] tx, input int n);
      logic [15:0] r;
      fsp_spi_host_i.frame(tx, 8 * n, r);
   endtask

   task automatic idle();
      for (int i = 0; i < 1000 && busy; i++) @(posedge clock);
   endtask

   task automatic status_write_cmd(input logic [15:0] sr);
      cmd(32'h06, 1);
      cmd({8'h00, 8'h01, sr[7:0], sr[15:8]}, 3);
      idle();
   endtask

   task automatic erase(input logic [39:0] tx, input int n, input logic ok);
      int s0;
      s0 = starts;
      cmd(32'h06, 1);
      cmd(tx, n);
      chk("erase", {21'h0, ok, ok, 1'b0}, {21'h0, starts != s0, busy, latch});
      idle();
   endtask

   task automatic power(input logic [15:0] img);
      @(posedge clock) #1 arst_n = 1'b0;
      nv_in = img;
      repeat (6) @(posedge clock);
      #1 arst_n = 1'b1;
      repeat (8) @(posedge clock);
   endtask

   task automatic conclude();
      $display("checks %0d, errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_latch();
      logic [15:0] r;
      chk("flags", 24'h0, {8'h0, nv} | {17'h0, busy, latch, susp, qe, dcs, lock});
      cmd(32'h06, 1);
      fsp_spi_host_i.frame(32'h0500, 16, r);
      chk("status_low", 24'h02, {16'h0, r[7:0]});
      chk("so_oe_n", 24'h1, {23'h0, oe_n});
      cmd(32'h04, 1);
      cmd(32'h010400, 3);
      chk("nv_latch", 24'h0, {7'h0, latch, nv});
   endtask

   task automatic t_suspend();
      cmd(32'h06, 1);
      cmd(32'h20000000, 4);
      cmd(32'h75, 1);
      chk("susp_busy", 24'h2, {22'h0, susp, busy});
      cmd(32'h7a, 1);
      chk("susp_busy", 24'h1, {22'h0, susp, busy});
      cmd(32'h75, 1);
      cmd(32'h66, 1);
      cmd(32'h99, 1);
      chk("reset_abort", 24'h1, {21'h0, susp, busy, aborts == 1});
      cmd(32'h06, 1);
      cmd(32'h66, 1);
      cmd(32'h99, 1);
      chk("latch", 24'h0, {23'h0, latch});
      idle();
   endtask

   task automatic t_protect();
      erase(32'hc7, 1, 1'b1);
      chk("kind", {21'h0, FSP_K_CHIP}, {21'h0, kind});
      status_write_cmd(16'h0004);
      erase(32'h200f0000, 4, 1'b0);
      erase(32'h200e0000, 4, 1'b1);
      chk("addr", 24'h0e0000, addr);
      erase(40'h020f00005a, 5, 1'b0);
      erase(40'h020e01005a, 5, 1'b1);
      chk("kind", {21'h0, FSP_K_PAGE}, {21'h0, kind});
      erase(32'h60, 1, 1'b0);
      status_write_cmd(16'h4024);
      erase(32'hd8000000, 4, 1'b1);
      erase(32'h52010000, 4, 1'b0);
      status_write_cmd(16'h4044);
      erase(32'h200ff000, 4, 1'b1);
      erase(32'h200fe000, 4, 1'b0);
      status_write_cmd(16'h401c);
      erase(32'h60, 1, 1'b1);
   endtask

   task automatic t_guard();
      logic [15:0] r;
      status_write_cmd(16'h1e00);
      chk("cfg", 24'h0f, {20'h0, qe, dcs, lock});
      fsp_spi_host_i.frame(40'h3500, 16, r);
      chk("status_high", 24'h1e, {16'h0, r[7:0]});
      status_write_cmd(16'h0080);
      @(posedge clock) #1 wp_n = 1'b0;
      status_write_cmd(16'h0084);
      chk("nv", 24'h0c80, {8'h0, nv});
      @(posedge clock) #1 wp_n = 1'b1;
      status_write_cmd(16'h0104);
      status_write_cmd(16'h0000);
      chk("nv", 24'h0d04, {8'h0, nv});
      power(nv);
      chk("nv", 24'h0c04, {8'h0, nv});
      status_write_cmd(16'h0180);
      status_write_cmd(16'h0000);
      chk("nv", 24'h0d80, {8'h0, nv});
   endtask

   initial begin
      power(16'h0000);
      t_latch();
      t_suspend();
      t_protect();
      t_guard();
      conclude();
   end
endmodule // tb_fsp_status_protect

`default_nettype wire
